// File: mte_core.sv
// Execution core for data transfer, bit, shift and flag-branch instructions
// Contract
// - Overflow-clear, irq-enabled, irq-disabled branches jump to pc+k+1; 1 or 2 cycles.
// - Post-increment load reads at pointer, then pointer plus one; two cycles.
// - Pre-decrement load subtracts one first, reads at new pointer; two cycles.
// - Displaced load reads at Y or Z plus q, pointer kept; two cycles.
// - Direct load reads the address word into destination; two cycles.
// - Post-increment store writes at pointer, then pointer plus one; two cycles.
// - Pre-decrement store subtracts one first, writes at new pointer; two cycles.
// - Displaced store writes at Y or Z plus q, pointer kept; two cycles.
// - Direct store writes source at the address word; two cycles.
// - Program memory read of byte at Z, or at Y for the implied-operand form, optional Z increment; three cycles.
// - Push puts source on stack in two cycles, flags unchanged.
// - Pop loads destination from stack in two cycles, flags unchanged.
// - I/O bit set forces one bit high, others kept; two cycles.
// - I/O bit clear forces one bit low, others kept; two cycles.
// - Shift left logical, zero into bit 0, updates Z C N V; one cycle.
// - Shift right logical, zero into bit 7, updates Z C N V; one cycle.
// - Rotate left through carry, carry from old bit 7; one cycle.
// - Rotate right through carry, carry from old bit 0; one cycle.
// - Arithmetic shift right keeps bit 7, updates Z C N V; one cycle.
// - Nibble swap exchanges halves in one cycle, no flag changes.
// - Bit store copies selected register bit into T in one cycle.
// - Bit load copies T into selected register bit; no flag changes.
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module mte_core
  import mte_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic      [15:0]      progAddr,
  input  wire logic [15:0]      progInstr,
  input  wire logic [15:0]      progNext,
  output logic      [14:0]      progRdAddr,
  input  wire logic [15:0]      progRdData,
  output mte_dmem_req_type      dmemReq,
  input  wire logic [7:0]       dmemRdData,
  output mte_io_req_type        ioReq,
  input  wire logic [7:0]       ioRdData
);

  mte_state_type    state_reg, state_next;
  logic [15:0]      pc_reg, pc_next, sp_reg, sp_next;
  logic [7:0]       status_register_reg, status_register_next;
  logic             run_reg;
  logic [7:0]       rf_reg [32];
  logic             ldPend_reg, ldPend_next, ldHigh_reg, ldHigh_next;
  logic [4:0]       ldDst_reg, ldDst_next;
  mte_ldsrc_type    ldSrc_reg, ldSrc_next;
  logic             rmw_reg, rmw_next, rmwSet_reg, rmwSet_next;
  logic [7:0]       rmwMask_reg, rmwMask_next;
  mte_dmem_req_type dmemReq_reg, dmemReq_next;
  mte_io_req_type   ioReq_reg, ioReq_next;
  logic [14:0]      progRdAddr_reg, progRdAddr_next;
  logic [7:0]       ldData, opA, opB, rfVal, shRes;
  logic [4:0]       rfIdx, ptrLo;
  logic             rfWe, ptrWe, shDo, shC, bitSel;
  logic [15:0]      ptrCur, ptrVal, brTarget;
  logic [15:0]      ins;
  logic             evBrTaken, evLdPost, evLdPre, evStPost, evLpm, evSbi, evSwap, evBst;

  assign ins        = progInstr;
  assign progAddr   = pc_reg;
  assign progRdAddr = progRdAddr_reg;
  assign dmemReq    = dmemReq_reg;
  assign ioReq      = ioReq_reg;

  // Returning byte of the load issued one cycle earlier
  always_comb
  begin
    unique case (ldSrc_reg)
      LD_IO:   ldData = ioRdData;
      LD_PROG: ldData = ldHigh_reg ? progRdData[15:8] : progRdData[7:0];
      default: ldData = dmemRdData;
    endcase
  end

  // Register read with forwarding of a load still being written back
  function automatic logic [7:0] regRd(input logic [4:0] i);
    regRd = (ldPend_reg && ldDst_reg == i) ? ldData : rf_reg[i];
  endfunction

  assign opA      = regRd(ins[8:4]);
  assign opB      = regRd({ins[9], ins[3:0]});
  assign ptrCur   = {regRd(ptrLo + 5'h01), regRd(ptrLo)};
  assign brTarget = pc_reg + 16'h0001 + {{9{ins[9]}}, ins[9:3]};
  assign bitSel   = opA[ins[2:0]];

  // Pointer pair named by the instruction
  always_comb
  begin
    if (ins[15:12] == 4'h8 || ins[15:12] == 4'hA)
      ptrLo = ins[3] ? PTR_Y_LO : PTR_Z_LO;
    else if (ins[3:2] == 2'b11)
      ptrLo = PTR_X_LO;
    else if (ins[3:2] == 2'b10)
      ptrLo = PTR_Y_LO;
    else
      ptrLo = PTR_Z_LO;
  end

  // Decode and sequencing
  always_comb
  begin
    state_next      = S_DECODE;
    pc_next         = pc_reg;
    sp_next         = sp_reg;
    status_register_next       = status_register_reg;
    rfWe            = 1'b0;
    rfIdx           = ins[8:4];
    rfVal           = opB;
    ptrWe           = 1'b0;
    ptrVal          = ptrCur;
    dmemReq_next    = '0;
    ioReq_next      = '0;
    progRdAddr_next = progRdAddr_reg;
    ldPend_next     = 1'b0;
    ldDst_next      = ldDst_reg;
    ldSrc_next      = ldSrc_reg;
    ldHigh_next     = ldHigh_reg;
    rmw_next        = 1'b0;
    rmwSet_next     = rmwSet_reg;
    rmwMask_next    = rmwMask_reg;
    shDo            = 1'b0;
    shC             = 1'b0;
    shRes           = opA;
    evBrTaken       = 1'b0;
    evLdPost        = 1'b0;
    evLdPre         = 1'b0;
    evStPost        = 1'b0;
    evLpm           = 1'b0;
    evSbi           = 1'b0;
    evSwap          = 1'b0;
    evBst           = 1'b0;
    unique case (state_reg)
      S_HOLD2: state_next = S_HOLD1;
      S_HOLD1:
      begin
        // Second half of read-modify-write; write lands during the next cycle
        if (rmw_reg)
        begin
          ioReq_next.addr   = ioReq_reg.addr;
          ioReq_next.we     = 1'b1;
          ioReq_next.wrData = rmwSet_reg ? (ioRdData | rmwMask_reg)
                                         : (ioRdData & ~rmwMask_reg);
        end
      end
      S_DECODE:
      begin
        if (run_reg)
        begin
          pc_next = pc_reg + 16'h0001;
          casez (ins)
            16'b0010_11??_????_????:
            begin
              rfWe = 1'b1;
            end
            16'b1110_????_????_????:
            begin
              rfWe  = 1'b1;
              rfIdx = {1'b1, ins[7:4]};
              rfVal = {ins[11:8], ins[3:0]};
            end
            16'b0000_11??_????_????:
            begin
              // Register added to itself is the left shift
              shDo  = (ins[8:4] == {ins[9], ins[3:0]});
              shRes = {opA[6:0], 1'b0};
              shC   = opA[7];
            end
            16'b0001_11??_????_????:
            begin
              shDo  = (ins[8:4] == {ins[9], ins[3:0]});
              shRes = {opA[6:0], status_register_reg[FLAG_C]};
              shC   = opA[7];
            end
            16'b1001_0101_1100_1000, 16'b1001_000?_????0100, 16'b1001_000?_????0101:
            begin
              evLpm           = 1'b1;
              progRdAddr_next = ptrCur[15:1];
              ldPend_next     = 1'b1;
              ldSrc_next      = LD_PROG;
              ldHigh_next     = ptrCur[0];
              ldDst_next      = ins[9] ? 5'h00 : ins[8:4];
              ptrWe           = (ins[3:0] == 4'h5);
              ptrVal          = ptrCur + 16'h0001;
              state_next      = mte_hold_for(CYC_PROG);
            end
            16'b1001_000?_????0000, 16'b1001_001?_????0000:
            begin
              pc_next             = pc_reg + 16'h0002;
              dmemReq_next.addr   = progNext;
              dmemReq_next.wrData = opA;
              dmemReq_next.we     = ins[9];
              dmemReq_next.re     = ~ins[9];
              ldPend_next         = ~ins[9];
              ldSrc_next          = LD_DATA;
              ldDst_next          = ins[8:4];
              state_next          = mte_hold_for(CYC_MEM);
            end
            16'b1001_00??_????_1111:
            begin
              // Push writes then decrements; pop increments then reads
              dmemReq_next.addr   = ins[9] ? sp_reg : sp_reg + 16'h0001;
              dmemReq_next.wrData = opA;
              dmemReq_next.we     = ins[9];
              dmemReq_next.re     = ~ins[9];
              sp_next             = ins[9] ? sp_reg - 16'h0001 : sp_reg + 16'h0001;
              ldPend_next         = ~ins[9];
              ldSrc_next          = LD_DATA;
              ldDst_next          = ins[8:4];
              state_next          = mte_hold_for(CYC_MEM);
            end
            16'b1001_00??_????_0001, 16'b1001_00??_????_0010, 16'b1001_00??_????_1001,
            16'b1001_00??_????_1010, 16'b1001_00??_????_1100, 16'b1001_00??_????_1101,
            16'b1001_00??_????_1110:
            begin
              evLdPost            = ~ins[9] & (ins[1:0] == 2'b01);
              evLdPre             = ~ins[9] & (ins[1:0] == 2'b10);
              evStPost            = ins[9] & (ins[1:0] == 2'b01);
              ptrWe               = (ins[1:0] != 2'b00);
              ptrVal              = ins[1] ? ptrCur - 16'h0001 : ptrCur + 16'h0001;
              dmemReq_next.addr   = ins[1] ? ptrVal : ptrCur;
              dmemReq_next.wrData = opA;
              dmemReq_next.we     = ins[9];
              dmemReq_next.re     = ~ins[9];
              ldPend_next         = ~ins[9];
              ldSrc_next          = LD_DATA;
              ldDst_next          = ins[8:4];
              state_next          = mte_hold_for(CYC_MEM);
            end
            16'b10?0_????_????_????:
            begin
              dmemReq_next.addr   = ptrCur + {10'h000, ins[13], ins[11:10], ins[2:0]};
              dmemReq_next.wrData = opA;
              dmemReq_next.we     = ins[9];
              dmemReq_next.re     = ~ins[9];
              ldPend_next         = ~ins[9];
              ldSrc_next          = LD_DATA;
              ldDst_next          = ins[8:4];
              state_next          = mte_hold_for(CYC_MEM);
            end
            16'b1011_????_????_????:
            begin
              // Port read returns next cycle and is forwarded to the following instruction
              ioReq_next.addr   = {ins[10:9], ins[3:0]};
              ioReq_next.wrData = opA;
              ioReq_next.we     = ins[11];
              ioReq_next.re     = ~ins[11];
              ldPend_next       = ~ins[11];
              ldSrc_next        = LD_IO;
              ldDst_next        = ins[8:4];
            end
            16'b1001_10?0_????_????:
            begin
              evSbi           = ins[9];
              ioReq_next.addr = {1'b0, ins[7:3]};
              ioReq_next.re   = 1'b1;
              rmw_next        = 1'b1;
              rmwSet_next     = ins[9];
              rmwMask_next    = 8'h01 << ins[2:0];
              state_next      = mte_hold_for(CYC_MEM);
            end
            16'b1001_010?_????_0110:
            begin
              shDo  = 1'b1;
              shRes = {1'b0, opA[7:1]};
              shC   = opA[0];
            end
            16'b1001_010?_????_0111:
            begin
              shDo  = 1'b1;
              shRes = {status_register_reg[FLAG_C], opA[7:1]};
              shC   = opA[0];
            end
            16'b1001_010?_????_0101:
            begin
              shDo  = 1'b1;
              shRes = {opA[7], opA[7:1]};
              shC   = opA[0];
            end
            16'b1001_010?_????_0010:
            begin
              evSwap = 1'b1;
              rfWe   = 1'b1;
              rfVal  = {opA[3:0], opA[7:4]};
            end
            16'b1001_0100_????_1000:
            begin
              status_register_next[ins[6:4]] = ~ins[7];
            end
            16'b1111_101?_????_0???:
            begin
              evBst             = 1'b1;
              status_register_next[FLAG_T] = bitSel;
            end
            16'b1111_100?_????_0???:
            begin
              rfWe  = 1'b1;
              rfVal = opA;
              rfVal[ins[2:0]] = status_register_reg[FLAG_T];
            end
            16'b1111_0???_????_????:
            begin
              // Flag-set form when bit 10 is low, flag-clear form otherwise
              if (status_register_reg[ins[2:0]] != ins[10])
              begin
                evBrTaken  = 1'b1;
                pc_next    = brTarget;
                state_next = S_HOLD1;
              end
            end
            default: pc_next = pc_reg + 16'h0001;
          endcase
          if (shDo)
          begin
            rfWe              = 1'b1;
            rfVal             = shRes;
            status_register_next[FLAG_C] = shC;
            status_register_next[FLAG_Z] = (shRes == 8'h00);
            status_register_next[FLAG_N] = shRes[7];
            status_register_next[FLAG_V] = shRes[7] ^ shC;
          end
        end
      end
      default: state_next = S_DECODE;
    endcase
  end

  // Program counter and state
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_reg <= S_DECODE;
      pc_reg    <= PC_RESET;
    end
    else
    begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
    end
  end

  // Status register and stack pointer
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      status_register_reg <= STATUS_REGISTER_RESET;
      sp_reg   <= SP_RESET;
    end
    else
    begin
      status_register_reg <= status_register_next;
      sp_reg   <= sp_next;
    end
  end

  // Pending load and read-modify-write tracking
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ldPend_reg  <= 1'b0;
      ldDst_reg   <= 5'h00;
      ldSrc_reg   <= LD_DATA;
      ldHigh_reg  <= 1'b0;
      rmw_reg     <= 1'b0;
      rmwSet_reg  <= 1'b0;
      rmwMask_reg <= 8'h00;
    end
    else
    begin
      ldPend_reg  <= ldPend_next;
      ldDst_reg   <= ldDst_next;
      ldSrc_reg   <= ldSrc_next;
      ldHigh_reg  <= ldHigh_next;
      rmw_reg     <= rmw_next;
      rmwSet_reg  <= rmwSet_next;
      rmwMask_reg <= rmwMask_next;
    end
  end

  // Memory and port requests, registered so outputs are glitch free
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      dmemReq_reg    <= '0;
      ioReq_reg      <= '0;
      progRdAddr_reg <= 15'h0000;
    end
    else
    begin
      dmemReq_reg    <= dmemReq_next;
      ioReq_reg      <= ioReq_next;
      progRdAddr_reg <= progRdAddr_next;
    end
  end

  // Register file; a decode write wins over an older pending load
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 32; i++)
        rf_reg[i] <= 8'h00;
    end
    else
    begin
      if (ldPend_reg)
        rf_reg[ldDst_reg] <= ldData;
      if (ptrWe)
      begin
        rf_reg[ptrLo]          <= ptrVal[7:0];
        rf_reg[ptrLo + 5'h01]  <= ptrVal[15:8];
      end
      if (rfWe)
        rf_reg[rfIdx] <= rfVal;
    end
  end

  // Wishbone slave: registered answer one cycle after the request, one wait state
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      run_reg  <= CTRL_RUN_RESET;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      // Write lands on the acked edge, while the master still holds the request
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
          && wb_adr_i == WB_CTRL_ADDR)
        run_reg <= wb_dat_i[CTRL_RUN_BIT];
      unique case (wb_adr_i)
        WB_CTRL_ADDR:   wb_dat_o <= {31'h0000_0000, run_reg};
        WB_STATUS_ADDR: wb_dat_o <= {23'h00_0000, state_reg != S_DECODE, status_register_reg};
        WB_PC_ADDR:     wb_dat_o <= {16'h0000, pc_reg};
        default:        wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence lpmHold;
    state_reg == S_HOLD2 ##1 state_reg == S_HOLD1 ##1 state_reg == S_DECODE;
  endsequence

  branch_target_a: assert property (evBrTaken |=> pc_reg == $past(brTarget)
    && state_reg == S_HOLD1 ##1 state_reg == S_DECODE) else $error("branch target wrong");
  postinc_load_a: assert property (evLdPost |=> dmemReq.re
    && dmemReq.addr == $past(ptrCur) ##1 state_reg == S_DECODE) else $error("post-inc load");
  predec_addr_a: assert property (evLdPre |=> dmemReq.re
    && dmemReq.addr == $past(ptrCur) - 16'h0001) else $error("pre-dec address");
  store_pulse_a: assert property (evStPost |=> dmemReq.we
    && dmemReq.wrData == $past(opA) ##1 !dmemReq.we) else $error("store pulse");
  lpm_three_a: assert property (evLpm |=> lpmHold) else $error("lpm not three cycles");
  io_set_a: assert property (evSbi |=> ioReq.re ##1 ioReq.we
    && ioReq.wrData == ($past(ioRdData) | $past(rmwMask_reg))) else $error("io bit set");
  swap_flags_a: assert property (evSwap |=> status_register_reg == $past(status_register_reg))
    else $error("swap changed flags");
  bit_store_a: assert property (evBst |=> status_register_reg[FLAG_T] == $past(bitSel))
    else $error("bit store to T");

endmodule

// File: mte_mem_model.sv
// Behavioural program, data and I/O memories facing the execution core
`timescale 1ns/1ps
module mte_mem_model
  import mte_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic [15:0]      progAddr,
  output logic      [15:0]      progInstr,
  output logic      [15:0]      progNext,
  input  wire logic [14:0]      progRdAddr,
  output logic      [15:0]      progRdData,
  input  wire mte_dmem_req_type dmemReq,
  output logic      [7:0]       dmemRdData,
  input  wire mte_io_req_type   ioReq,
  output logic      [7:0]       ioRdData
);
  logic [15:0] rom [0:127];
  logic [7:0]  dmem [0:255];
  logic [7:0]  iom [0:63];
  logic [7:0]  lastD;
  logic [7:0]  lastIo;

  // Code above word 31 fetches as no-op, so constant words there are never run
  assign progInstr  = (progAddr < 16'h0020) ? rom[progAddr[6:0]] : 16'h0000;
  assign progNext   = (progAddr < 16'h001F) ? rom[progAddr[6:0] + 7'h01] : 16'h0000;
  assign progRdData = rom[progRdAddr[6:0]];
  // Released read lines show the inverse of the last value, not a stale copy
  assign dmemRdData = dmemReq.re ? dmem[dmemReq.addr[7:0]] : ~lastD;
  assign ioRdData   = ioReq.re ? iom[ioReq.addr] : ~lastIo;

  // Writes land on the edge that samples the strobe
  always @(posedge core_clk)
  begin
    if (dmemReq.we)
      dmem[dmemReq.addr[7:0]] <= dmemReq.wrData;
    if (dmemReq.re)
      lastD <= dmem[dmemReq.addr[7:0]];
    if (ioReq.we)
      iom[ioReq.addr] <= ioReq.wrData;
    if (ioReq.re)
      lastIo <= iom[ioReq.addr];
  end
endmodule

// File: mte_pkg.sv
// Shared constants, states and request carriers for the transfer/bit execution core
package mte_pkg;
  // Register bus word offsets
  localparam logic [3:0]  WB_CTRL_ADDR   = 4'h0;
  localparam logic [3:0]  WB_STATUS_ADDR = 4'h4;
  localparam logic [3:0]  WB_PC_ADDR     = 4'h8;
  localparam int          CTRL_RUN_BIT   = 0;
  localparam logic        CTRL_RUN_RESET = 1'b1;
  localparam int          STATUS_BUSY_BIT = 8;
  // Reset values
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [15:0] SP_RESET   = 16'h00FF;
  localparam logic [7:0]  STATUS_REGISTER_RESET = 8'h00;
  // Status register flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  // Low byte index of each pointer pair
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  // Cycle counts per instruction class
  localparam int CYC_ONE  = 1;
  localparam int CYC_MEM  = 2;
  localparam int CYC_PROG = 3;

  typedef enum logic [1:0] {
    S_DECODE = 2'b00,
    S_HOLD1  = 2'b01,
    S_HOLD2  = 2'b10
  } mte_state_type;

  typedef enum logic [1:0] {
    LD_DATA = 2'b00,
    LD_IO   = 2'b01,
    LD_PROG = 2'b10
  } mte_ldsrc_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wrData;
    logic        re;
    logic        we;
  } mte_dmem_req_type;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wrData;
    logic       re;
    logic       we;
  } mte_io_req_type;

  // Hold state entered after decode for an instruction of n cycles
  function automatic mte_state_type mte_hold_for(input int n);
    mte_hold_for = (n == CYC_PROG) ? S_HOLD2 : (n == CYC_MEM) ? S_HOLD1 : S_DECODE;
  endfunction
endpackage

// File: tb_top.sv
// Self-checking bench running one short fixed program with random operands on the execution core
`timescale 1ns/1ps
module tb_top;
  import mte_pkg::*;
  logic             core_clk = 1'b0;
  logic             resetn = 1'b0;
  logic             cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]       adr = 4'h0, sel = 4'h0;
  logic [31:0]      datI = 32'h0, datO, rd;
  logic             ack;
  logic [15:0]      progAddr, progInstr, progNext, progRdData;
  logic [14:0]      progRdAddr;
  logic [7:0]       dmemRdData, ioRdData, v, w, r16, pc0;
  logic [15:0]      p;
  mte_dmem_req_type dmemReq;
  mte_io_req_type   ioReq;
  int               n_errors = 0;
  int               tests_run = 0;

  always #12.5 core_clk = ~core_clk;

  mte_core dut (.core_clk(core_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
    .wb_ack_o(ack), .progAddr(progAddr), .progInstr(progInstr), .progNext(progNext),
    .progRdAddr(progRdAddr), .progRdData(progRdData), .dmemReq(dmemReq),
    .dmemRdData(dmemRdData), .ioReq(ioReq), .ioRdData(ioRdData));
  mte_mem_model mem (.core_clk(core_clk), .progAddr(progAddr), .progInstr(progInstr),
    .progNext(progNext), .progRdAddr(progRdAddr), .progRdData(progRdData),
    .dmemReq(dmemReq), .dmemRdData(dmemRdData), .ioReq(ioReq), .ioRdData(ioRdData));

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Classic single cycle; the request holds until ack is seen on a rising edge
  task automatic wb_cycle(input logic wr, input logic [3:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= wr; adr <= a; datI <= d; sel <= 4'hF;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = datO;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 20)
    begin
      chk(32'h0, 32'h1, "bus answer missing");
      final_report();
    end
  endtask

  // Immediate load word for a register of the upper half
  function automatic logic [15:0] load_immediate(input logic [4:0] d, input logic [7:0] k);
    load_immediate = {4'hE, k[7:4], d[3:0], k[3:0]};
  endfunction

  task automatic load_program();
    logic [15:0] prog [0:30];
    prog = '{16'hE1A0, 16'hE0B0, load_immediate(5'h10, v), 16'h930D, 16'h930D, 16'h911E, 16'h0F00,
             16'h9300, 16'h0020, 16'h9310, 16'h0021, 16'h930F, 16'h9A2B, 16'h9828,
             16'hEFEF, 16'hE0F0, 16'h9124, 16'h9320, 16'h0022, 16'h9512, 16'h9310,
             16'h0023, 16'h913D, 16'hFB37, 16'hF40E, 16'hF930, 16'h9330, 16'h0024,
             16'h914F, 16'h9340, 16'h0025};
    // Tail: post-inc load, bit to T, branch on T clear over a bit load, pop
    for (int i = 0; i < 128; i++)
      mem.rom[i] = (i < 31) ? prog[i] : 16'h0000;
    mem.rom[127] = p;
    for (int i = 0; i < 256; i++)
      mem.dmem[i] = 8'h00;
    mem.iom[5] = w;
  endtask

  initial
  begin
    void'($urandom(13123));
    for (int it = 0; it < 6; it++)
    begin
      // Corner values first, then random ones
      v = (it == 0) ? 8'h80 : (it == 1) ? 8'h00 : 8'($urandom());
      w = 8'($urandom());
      p = 16'($urandom());
      load_program();
      @(posedge core_clk);
      resetn <= 1'b0;
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (80) @(posedge core_clk);
      r16 = {v[6:0], 1'b0};
      chk(32'(mem.dmem[8'h10]), 32'(v), "store post-inc first");
      chk(32'(mem.dmem[8'h11]), 32'(v), "store post-inc second");
      chk(32'(mem.dmem[8'h20]), 32'(r16), "shift left result");
      chk(32'(mem.dmem[8'h21]), 32'(v), "pre-dec load value");
      chk(32'(mem.dmem[8'hFF]), 32'(r16), "push at stack top");
      chk(32'(mem.iom[5]), 32'((w | 8'h08) & 8'hFE), "io bit set clear");
      chk(32'(mem.dmem[8'h22]), 32'(p[15:8]), "program byte odd");
      chk(32'(mem.dmem[8'h23]), 32'({v[3:0], v[7:4]}), "nibble swap");
      chk(32'(mem.dmem[8'h24]), 32'(v | {7'h00, v[7]}), "T branch");
      chk(32'(mem.dmem[8'h25]), 32'(r16), "pop from stack top");
      wb_cycle(1'b0, WB_STATUS_ADDR, 32'h0, rd);
      chk(32'(rd[3:0]), 32'({v[7] ^ v[6], v[6], r16 == 8'h00, v[7]}), "shift flags");
      chk(32'(rd[7:6]), 32'({1'b0, v[7]}), "T set, I untouched");
      // Stopping the core must freeze the program counter
      wb_cycle(1'b1, WB_CTRL_ADDR, 32'h0, rd);
      wb_cycle(1'b0, WB_PC_ADDR, 32'h0, rd);
      pc0 = rd[7:0];
      repeat (3) @(posedge core_clk);
      wb_cycle(1'b0, WB_PC_ADDR, 32'h0, rd);
      chk(32'(rd[7:0]), 32'(pc0), "pc frozen when stopped");
      wb_cycle(1'b0, 4'hC, 32'h0, rd);
      chk(rd, 32'h0, "unmapped read");
    end
    final_report();
  end
endmodule
